// *** dv/dci_conv_model.sv ***
`timescale 1ns/1ps
module dci_conv_model import dci_pkg::*; (
  input  wire dci_conv_t   i_conv,
  output logic      [11:0] o_pin_dflt,
  output logic      [11:0] o_pin_alt
);
  // Disabled or unselected pins settle to ground via the pull-down
  wire on = !i_conv.out_hiz;
  assign o_pin_dflt = on && !i_conv.pin_alt ? i_conv.code : 12'h000;
  assign o_pin_alt  = on && i_conv.pin_alt ? i_conv.code : 12'h000;
endmodule : dci_conv_model

// *** dv/dci_top_sva.sv ***
`timescale 1ns/1ps
module dci_top_sva import dci_pkg::*; (
  input wire logic         i_clk,
  input wire logic         i_sys_rst,
  input wire dci_sfr_req_t i_sfr,
  input wire logic [7:0]   o_sfr_rdata,
  input wire dci_conv_t    o_conv
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire       w = i_sfr.wr && i_sfr.addr == 8'hfd;
  wire [7:0] d = i_sfr.wdata;
  a_high_hold: assert property (
    i_sfr.wr && i_sfr.addr == 8'hfc |=> $stable(o_conv.code))
    else $error("high byte write moved code");
  a_pin_sel: assert property (
    w |=> o_conv.pin_alt == $past(d[4])) else $error("pin select");
  a_range_sel: assert property (
    w |=> o_conv.range_supply == $past(d[2])) else $error("range");
  a_power_ctl: assert property (
    w |-> ##1 o_conv.power_down != $past(d[0])) else $error("power");
  a_clear_code: assert property (
    w && !d[1] |=> o_conv.code == 12'h000) else $error("clear");
  a_rsv_zero: assert property (
    i_sfr.rd && i_sfr.addr == 8'hfd |=> o_sfr_rdata[7:5] == 3'h0)
    else $error("reserved bits read back");
  a_hiz_pd: assert property (
    o_conv.out_hiz == o_conv.power_down) else $error("hiz");
  a_rst_state: assert property (disable iff (1'b0)
    i_sys_rst |=> o_conv.power_down && o_conv.code == 12'h000)
    else $error("reset state");
endmodule : dci_top_sva
bind dci_top dci_top_sva u_sva (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_sfr(i_sfr), .o_sfr_rdata(o_sfr_rdata), .o_conv(o_conv));

// *** dv/dci_top_tb.sv ***
`timescale 1ns/1ps
module dci_top_tb;
  import dci_pkg::*;
  logic         i_clk = 0, i_sys_rst = 1;
  dci_sfr_req_t sfr = '0;
  logic [7:0]   rdat;
  dci_conv_t    cv;
  logic [11:0]  p_d, p_a;
  int           err_count = 0, samples_checked = 0;
  always #10 i_clk = ~i_clk;
  dci_top DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sfr(sfr),
    .o_sfr_rdata(rdat), .o_conv(cv));
  dci_conv_model u_cm (.i_conv(cv), .o_pin_dflt(p_d), .o_pin_alt(p_a));
  task chk(input logic [15:0] s, e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task xfer(input logic w, input logic [7:0] a, dt);
    @(negedge i_clk);
    sfr = '{w, !w, a, dt};
    @(negedge i_clk);
    sfr = '0;
  endtask : xfer
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  initial begin
    repeat (8) @(posedge i_clk);
    @(negedge i_clk);
    i_sys_rst = 0;
    chk(cv, 16'h0003);
    for (int a = 'hfb; a < 'hfe; a++) begin
      xfer(0, 8'(a), 8'h00);
      chk(rdat, 16'h0000);
    end
    $display("reset test done");
    xfer(1, 8'hfd, 8'h03);
    xfer(1, 8'hfc, 8'h0a);
    chk(cv.code, 16'h0000);
    xfer(1, 8'hfb, 8'hbc);
    chk(cv.code, 16'h0abc);
    chk(p_d, 16'h0abc);
    $display("word test done");
    xfer(1, 8'hfd, 8'hff);
    xfer(1, 8'hfb, 8'h5c);
    chk(cv, 16'h5c0c);
    chk(p_a, 16'h05c0);
    xfer(0, 8'hfd, 8'h00);
    chk(rdat, 16'h001f);
    $display("byte test done");
    xfer(1, 8'hfd, 8'h01);
    chk(cv, 16'h0000);
    xfer(1, 8'hfb, 8'h77);
    xfer(0, 8'hfb, 8'h00);
    chk(rdat, 16'h0000);
    xfer(1, 8'hfd, 8'h00);
    chk(cv[1:0], 16'h0003);
    $display("clear test done");
    summarize;
  end
endmodule : dci_top_tb

// *** src/dci_code_form.sv ***
`timescale 1ns/1ps
module dci_code_form (
  // Data bytes and mode
  input  wire logic [7:0]  i_low,
  input  wire logic [7:0]  i_high,
  input  wire logic        i_byte_mode,
  // Formed code
  output logic      [11:0] o_code
);
  import dci_pkg::*;

  always_comb begin
    if (i_byte_mode) begin
      o_code = {i_low, 4'h0};
    end else begin
      o_code = {i_high[3:0], i_low};
    end
  end

endmodule : dci_code_form

// *** src/dci_pkg.sv ***
package dci_pkg;

  localparam logic [7:0] DCI_ADDR_LOW  = 8'hfb;
  localparam logic [7:0] DCI_ADDR_HIGH = 8'hfc;
  localparam logic [7:0] DCI_ADDR_CTRL = 8'hfd;

  localparam logic [7:0] DCI_RST_LOW   = 8'h00;
  localparam logic [7:0] DCI_RST_HIGH  = 8'h00;
  localparam logic [7:0] DCI_RST_CTRL  = 8'h00;
  localparam logic [7:0] DCI_CTRL_MASK = 8'h1f;

  localparam int DCI_BIT_PIN   = 4;
  localparam int DCI_BIT_BYTE  = 3;
  localparam int DCI_BIT_RANGE = 2;
  localparam int DCI_BIT_CLRN  = 1;
  localparam int DCI_BIT_PWR   = 0;

  localparam int DCI_CODE_W = 12;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dci_sfr_req_t;

  typedef struct packed {
    logic [11:0] code;
    logic        pin_alt;
    logic        range_supply;
    logic        power_down;
    logic        out_hiz;
  } dci_conv_t;

endpackage : dci_pkg

// *** src/dci_top.sv ***
`timescale 1ns/1ps
module dci_top (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  // Special-function register bus
  input  wire dci_pkg::dci_sfr_req_t i_sfr,
  output logic [7:0]                 o_sfr_rdata,
  // Converter controls
  output dci_pkg::dci_conv_t         o_conv
);
  import dci_pkg::*;

  // Code value that reset leaves behind, built from the data resets
  localparam logic [11:0] CODE_RST = {DCI_RST_HIGH[3:0], DCI_RST_LOW};

  // Bus decode
  logic        wr_low;
  logic        wr_high;
  logic        wr_ctrl;
  logic        rd_req;

  // Control register
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_d;

  // Data registers
  logic [7:0]  low_q;
  logic [7:0]  low_d;
  logic [7:0]  high_q;
  logic [7:0]  high_d;
  logic        clear_n;

  // Converter code
  logic [11:0] code_q;
  logic [11:0] code_d;
  logic [11:0] formed;

  // Read data
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;

  // Analog-side control flops
  logic        pin_q;
  logic        pin_d;
  logic        range_q;
  logic        range_d;
  logic        pdown_q;
  logic        pdown_d;
  logic        hiz_q;
  logic        hiz_d;

  function automatic logic hit(
    input dci_sfr_req_t r,
    input logic [7:0]   a
  );
    hit = r.addr == a;
  endfunction : hit

  // ---------------------------------------------------------------
  // Decode
  always_comb begin
    wr_low  = i_sfr.wr && hit(i_sfr, DCI_ADDR_LOW);
    wr_high = i_sfr.wr && hit(i_sfr, DCI_ADDR_HIGH);
    wr_ctrl = i_sfr.wr && hit(i_sfr, DCI_ADDR_CTRL);
    rd_req  = i_sfr.rd;
  end

  // ---------------------------------------------------------------
  // Control register
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      // Reserved bits never store, so they always read back as zero
      ctrl_d = i_sfr.wdata & DCI_CTRL_MASK;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_q <= DCI_RST_CTRL;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ---------------------------------------------------------------
  // Data registers
  // The clear bit is taken from the next control value, so a write
  // that clears it empties the data in the same cycle.
  always_comb begin
    low_d   = low_q;
    high_d  = high_q;
    clear_n = ctrl_d[DCI_BIT_CLRN];
    if (wr_low) begin
      low_d = i_sfr.wdata;
    end
    if (wr_high) begin
      // Stored only; the code does not follow a high-byte write
      high_d = i_sfr.wdata;
    end
    if (!clear_n) begin
      low_d  = 8'h00;
      high_d = 8'h00;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      low_q  <= DCI_RST_LOW;
      high_q <= DCI_RST_HIGH;
    end else begin
      low_q  <= low_d;
      high_q <= high_d;
    end
  end

  // ---------------------------------------------------------------
  // Converter code
  // Code as it will stand once the pending low-byte write lands
  dci_code_form u_form (
    .i_low       (low_d),
    .i_high      (high_d),
    .i_byte_mode (ctrl_d[DCI_BIT_BYTE]),
    .o_code      (formed)
  );

  always_comb begin
    code_d = code_q;
    // Code moves on a low-byte write or on a forced clear of the data
    if (wr_low || !clear_n) begin
      code_d = formed;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      code_q <= CODE_RST;
    end else begin
      code_q <= code_d;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // Held until the next read so software can sample it at leisure
  always_comb begin
    rdata_d = rdata_q;
    if (rd_req) begin
      unique case (i_sfr.addr)
        DCI_ADDR_LOW:  rdata_d = low_q;
        DCI_ADDR_HIGH: rdata_d = high_q;
        DCI_ADDR_CTRL: rdata_d = ctrl_q;
        default:       rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Analog-side controls
  // Kept in their own flops so every output leaves a register, with
  // no logic after the flops; the power bit is inverted ahead of the pdown and hiz flops.
  always_comb begin
    pin_d   = ctrl_d[DCI_BIT_PIN];
    range_d = ctrl_d[DCI_BIT_RANGE];
    pdown_d = !ctrl_d[DCI_BIT_PWR];
    hiz_d   = !ctrl_d[DCI_BIT_PWR];
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pin_q   <= DCI_RST_CTRL[DCI_BIT_PIN];
      range_q <= DCI_RST_CTRL[DCI_BIT_RANGE];
      pdown_q <= !DCI_RST_CTRL[DCI_BIT_PWR];
      hiz_q   <= !DCI_RST_CTRL[DCI_BIT_PWR];
    end else begin
      pin_q   <= pin_d;
      range_q <= range_d;
      pdown_q <= pdown_d;
      hiz_q   <= hiz_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  assign o_sfr_rdata         = rdata_q;
  assign o_conv.code         = code_q;
  assign o_conv.pin_alt      = pin_q;
  assign o_conv.range_supply = range_q;
  assign o_conv.power_down   = pdown_q;
  assign o_conv.out_hiz      = hiz_q;

endmodule : dci_top
